/* File: hw/dao_params.svh */
// Purpose: shared constants of the dual converter output control
// Assumes: included by its bare name from every design file
// Notes:   numbers only, no logic
`ifndef DAO_PARAMS_SVH
`define DAO_PARAMS_SVH

// conversion word width and the pipeline latency in conversion clocks
`define DAO_WORD_BITS     10
`define DAO_LATENCY       7
`define DAO_MSB_POS       9

// output buffer depth, in pairs of words
`define DAO_BUF_DEPTH     2

// synchroniser length for every pin input
`define DAO_SYNC_STAGES   2

// reset values of the output pins
`define DAO_WORD_RST      10'h000
`define DAO_OE_RST        1'b0
`define DAO_IND_RST       1'b0

// codes reported by the four-level detector on the format pin
`define DAO_LVL_SUPPLY    2'h0
`define DAO_LVL_GROUND    2'h1
`define DAO_LVL_MIDREF    2'h2
`define DAO_LVL_FLOAT     2'h3

`endif

/* File: hw/dao_pkg.sv */
// Purpose: types of the dual converter output control
// Assumes: dao_params.svh holds the numbers
// Notes:   types only
`include "dao_params.svh"

package dao_pkg;

  typedef logic [`DAO_WORD_BITS-1:0] dao_word_t;

  // output number format
  typedef enum logic {
    DAO_FMT_OFFSET_BINARY,
    DAO_FMT_TWOS_COMPLEMENT
  } dao_format_t;

  // sequencing of words onto the shared bus
  typedef enum {
    DAO_ST_FIRST,
    DAO_ST_SECOND
  } dao_out_state_t;

endpackage : dao_pkg

/* File: hw/dao_pair_buffer.sv */
// Purpose: small flop buffer with valid and ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   depth must be a power of two, at least two
`timescale 1ns/100ps
`include "dao_params.svh"

module dao_pair_buffer
  import dao_pkg::*;
#(
  parameter int WIDTH = 2 * `DAO_WORD_BITS,
  parameter int DEPTH = `DAO_BUF_DEPTH
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             reset_n,   // synchronous reset, active low
  input  wire logic             in_valid,  // producer offers a word
  output logic                  in_ready,  // buffer has room
  input  wire logic [WIDTH-1:0] in_data,   // offered word
  output logic                  out_valid, // head entry present
  input  wire logic             out_ready, // consumer takes the head
  output logic      [WIDTH-1:0] out_data   // head entry
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // index wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dao_pair_buffer: DEPTH must be a power of two, at least two");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = store[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_idx <= wr_idx + AW'(1);
      end
      if (pop) begin
        rd_idx <= rd_idx + AW'(1);
      end
      if (push && !pop) begin
        fill <= fill + (AW+1)'(1);
      end else if (pop && !push) begin
        fill <= fill - (AW+1)'(1);
      end
    end
  end

endmodule : dao_pair_buffer

/* File: hw/dao_output_control.sv */
// Purpose: digital control and output side of a dual 10-bit pipelined converter
// Assumes: conversion clock and control pins arrive asynchronously to clk_sys;
//          quantiser results arrive on clk_sys, offset binary, stable at the sample edge
// Notes:   each conversion clock is seen as a rising-edge pulse on clk_sys, so the
//          conversion clock must run well below a quarter of clk_sys
//
// Behaviour
// - a result leaves the pipeline seven conversion clocks after its sample edge
// - samples are taken only on rising conversion clock edges
// - an enable pin held low makes that channel's bus driven
// - an enable pin held high floats that channel's bus, per channel
// - sleep pin high stops conversion; low runs the converter
// - mode pin low: first channel on first bus, second on second bus
// - mode pin high: both channels share the first bus
// - format pin at supply: offset binary, duty stabiliser on
// - format pin at ground: two's complement, duty stabiliser on
// - format pin at mid reference: two's complement, duty stabiliser off
// - format pin floating: offset binary, duty stabiliser off
// - each word is ten bits, bit zero least significant, bit nine most
// - shared bus indicator high with first channel word, low with second
`timescale 1ns/100ps
`include "dao_params.svh"

module dao_output_control
  import dao_pkg::*;
#(
  parameter int WORD_BITS = `DAO_WORD_BITS,
  parameter int LATENCY   = `DAO_LATENCY,
  parameter int BUF_DEPTH = `DAO_BUF_DEPTH
) (
  input  wire logic                 clk_sys,                       // system clock, 250 MHz
  input  wire logic                 reset_n,                       // synchronous reset, active low
  input  wire logic                 conv_clk,                      // conversion clock pin
  input  wire logic [WORD_BITS-1:0] first_sample,                  // first quantiser result
  input  wire logic [WORD_BITS-1:0] second_sample,                 // second quantiser result
  input  wire logic                 first_bus_drive_enable_n,      // first bus enable pin
  input  wire logic                 second_bus_drive_enable_n,     // second bus enable pin
  input  wire logic                 sleep_request,                 // power down pin
  input  wire logic                 mux_mode_select,               // output mode pin
  input  wire logic [1:0]           format_and_stabiliser_select,  // four-level pin code
  input  wire logic                 sink_ready,                    // receiver takes the word
  output logic      [WORD_BITS-1:0] first_channel_word,            // first output bus
  output logic                      first_channel_word_oe,         // first bus driven
  output logic      [WORD_BITS-1:0] second_channel_word,           // second output bus
  output logic                      second_channel_word_oe,        // second bus driven
  output logic                      word_valid,                    // bus holds a fresh word
  output logic                      channel_indicator,             // shared bus channel flag
  output logic                      duty_stabilise_on,             // duty stabiliser applied
  output logic                      sleeping,                      // low power state
  output logic                      word_dropped                   // sticky, a pair was lost
);

  // elaboration checks; a one-stage pipeline has no shift path for the
  // valid bits, so two stages is the floor
  if (WORD_BITS != `DAO_WORD_BITS) begin : g_bad_width
    $error("dao_output_control: WORD_BITS must be the converter width");
  end
  if (LATENCY < 2) begin : g_bad_latency
    $error("dao_output_control: LATENCY must be at least two");
  end

  localparam int PAIR_BITS = 2 * WORD_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // offset binary to two's complement is a flip of the sign bit
  function automatic logic [WORD_BITS-1:0] fmt_word(
    input logic [WORD_BITS-1:0] raw,
    input dao_format_t          fmt
  );
    logic [WORD_BITS-1:0] res;
    res = raw;
    if (fmt == DAO_FMT_TWOS_COMPLEMENT) begin
      res[WORD_BITS-1] = ~raw[WORD_BITS-1];
    end
    return res;
  endfunction : fmt_word

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage is read only by the second

  logic       clk_s1;
  logic       clk_s2;
  logic       clk_prev;
  logic       oe1_s1;
  logic       oe1_s2;
  logic       oe2_s1;
  logic       oe2_s2;
  logic       sleep_s1;
  logic       sleep_s2;
  logic       mux_s1;
  logic       mux_s2;
  logic [1:0] fmt_s1;
  logic [1:0] fmt_s2;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clk_s1   <= 1'b0;
      clk_s2   <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      clk_s1   <= conv_clk;
      clk_s2   <= clk_s1;
      clk_prev <= clk_s2;
    end
  end

  // enables reset to the floating state, so pins start high-impedance
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oe1_s1   <= 1'b1;
      oe1_s2   <= 1'b1;
      oe2_s1   <= 1'b1;
      oe2_s2   <= 1'b1;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      mux_s1   <= 1'b0;
      mux_s2   <= 1'b0;
      fmt_s1   <= `DAO_LVL_FLOAT;
      fmt_s2   <= `DAO_LVL_FLOAT;
    end else begin
      oe1_s1   <= first_bus_drive_enable_n;
      oe1_s2   <= oe1_s1;
      oe2_s1   <= second_bus_drive_enable_n;
      oe2_s2   <= oe2_s1;
      sleep_s1 <= sleep_request;
      sleep_s2 <= sleep_s1;
      mux_s1   <= mux_mode_select;
      mux_s2   <= mux_s1;
      fmt_s1   <= format_and_stabiliser_select;
      fmt_s2   <= fmt_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample edge, format decode, sleep

  logic        sample_edge;
  dao_format_t out_format;
  logic        next_stabilise;

  assign sample_edge = clk_s2 & ~clk_prev & ~sleep_s2;

  always_comb begin
    case (fmt_s2)
      `DAO_LVL_SUPPLY: begin
        out_format     = DAO_FMT_OFFSET_BINARY;
        next_stabilise = 1'b1;
      end
      `DAO_LVL_GROUND: begin
        out_format     = DAO_FMT_TWOS_COMPLEMENT;
        next_stabilise = 1'b1;
      end
      `DAO_LVL_MIDREF: begin
        out_format     = DAO_FMT_TWOS_COMPLEMENT;
        next_stabilise = 1'b0;
      end
      default: begin
        out_format     = DAO_FMT_OFFSET_BINARY;
        next_stabilise = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      duty_stabilise_on <= 1'b0;
    end else begin
      duty_stabilise_on <= next_stabilise;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= sleep_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion pipeline, advanced once per sample edge

  logic [WORD_BITS-1:0] pipe_first  [LATENCY];
  logic [WORD_BITS-1:0] pipe_second [LATENCY];
  logic [LATENCY-1:0]   pipe_valid;
  logic                 buf_in_valid;
  logic                 buf_in_ready;
  logic [PAIR_BITS-1:0] buf_in_data;

  // seventh edge after the sample pushes the pair out
  assign buf_in_valid = sample_edge & pipe_valid[LATENCY-1];
  // bit zero stays the least significant bit
  assign buf_in_data  = {fmt_word(pipe_first[LATENCY-1], out_format),
                         fmt_word(pipe_second[LATENCY-1], out_format)};

  always_ff @(posedge clk_sys) begin
    if (sample_edge) begin
      pipe_first[0]  <= first_sample;
      pipe_second[0] <= second_sample;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_first[i]  <= pipe_first[i-1];
        pipe_second[i] <= pipe_second[i-1];
      end
    end
  end

  // sleeping empties the pipeline, so no stale word follows wake-up
  always_ff @(posedge clk_sys) begin
    if (!reset_n || sleep_s2) begin
      pipe_valid <= '0;
    end else if (sample_edge) begin
      pipe_valid <= {pipe_valid[LATENCY-2:0], 1'b1};
    end
  end

  // a converter cannot pause, so a full buffer costs the pair; flag it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      word_dropped <= 1'b0;
    end else if (buf_in_valid && !buf_in_ready) begin
      word_dropped <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer

  logic                 buf_out_valid;
  logic                 buf_pop;
  logic [PAIR_BITS-1:0] buf_out_data;

  dao_pair_buffer #(
    .WIDTH (PAIR_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencing

  dao_out_state_t       out_state;
  logic                 load_slot;
  logic [WORD_BITS-1:0] head_first;
  logic [WORD_BITS-1:0] head_second;

  assign head_first  = buf_out_data[PAIR_BITS-1:WORD_BITS];
  assign head_second = buf_out_data[WORD_BITS-1:0];
  assign load_slot   = ~word_valid | sink_ready;
  // in shared mode the pair leaves only after its second word
  assign buf_pop     = load_slot & buf_out_valid & (~mux_s2 | (out_state == DAO_ST_SECOND));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      out_state <= DAO_ST_FIRST;
    end else if (!mux_s2) begin
      out_state <= DAO_ST_FIRST;
    end else if (load_slot && buf_out_valid) begin
      case (out_state)
        DAO_ST_FIRST:  out_state <= DAO_ST_SECOND;
        DAO_ST_SECOND: out_state <= DAO_ST_FIRST;
        default:       out_state <= DAO_ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      word_valid <= 1'b0;
    end else if (load_slot) begin
      word_valid <= buf_out_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_channel_word  <= `DAO_WORD_RST;
      second_channel_word <= `DAO_WORD_RST;
      channel_indicator   <= `DAO_IND_RST;
    end else if (load_slot && buf_out_valid) begin
      if (mux_s2) begin
        // both words take the first bus in turn
        // indicator marks which channel is on it
        if (out_state == DAO_ST_SECOND) begin
          first_channel_word <= head_second;
          channel_indicator  <= 1'b0;
        end else begin
          first_channel_word <= head_first;
          channel_indicator  <= 1'b1;
        end
      end else begin
        // each channel on its own bus
        first_channel_word  <= head_first;
        second_channel_word <= head_second;
        channel_indicator   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drive enables

  // high pin floats it, each channel on its own
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_channel_word_oe  <= `DAO_OE_RST;
      second_channel_word_oe <= `DAO_OE_RST;
    end else begin
      first_channel_word_oe  <= ~oe1_s2;
      second_channel_word_oe <= ~oe2_s2;
    end
  end

endmodule : dao_output_control

/* File: tb/dao_output_control_asserts.sv */
// Purpose: port-level checks of the dual converter output control
// Assumes: pins held steady six cycles have passed the synchronisers
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
`include "dao_params.svh"

module dao_oc_chk
  import dao_pkg::*;
#(
  parameter int WORD_BITS = `DAO_WORD_BITS
) (
  input wire logic                 clk_sys,                      // clock
  input wire logic                 reset_n,                      // reset
  input wire logic                 first_bus_drive_enable_n,     // pin
  input wire logic                 second_bus_drive_enable_n,    // pin
  input wire logic                 sleep_request,                // pin
  input wire logic                 mux_mode_select,              // pin
  input wire logic [1:0]           format_and_stabiliser_select, // pin code
  input wire logic                 sink_ready,                   // receiver
  input wire logic [WORD_BITS-1:0] first_channel_word,           // bus
  input wire logic                 first_channel_word_oe,        // driven
  input wire logic                 second_channel_word_oe,       // driven
  input wire logic                 word_valid,                   // fresh word
  input wire logic                 channel_indicator,            // flag
  input wire logic                 duty_stabilise_on,            // stabiliser
  input wire logic                 sleeping                      // low power
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////
  // six steady cycles, since three are lost to the two synchroniser stages and the output flop
  sequence first_taken;
    mux_mode_select [*6] ##0 (word_valid && sink_ready && channel_indicator);
  endsequence
  sequence second_taken;
    mux_mode_select [*6] ##0 (word_valid && sink_ready && !channel_indicator);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  first_oe_a: assert property ($stable(first_bus_drive_enable_n) [*6]
    |-> first_channel_word_oe == !first_bus_drive_enable_n) else $error("first bus enable wrong");
  second_oe_a: assert property ($stable(second_bus_drive_enable_n) [*6]
    |-> second_channel_word_oe == !second_bus_drive_enable_n) else $error("second bus enable wrong");
  sleep_state_a: assert property ($stable(sleep_request) [*6]
    |-> sleeping == sleep_request) else $error("sleep state wrong");
  duty_select_a: assert property ($stable(format_and_stabiliser_select) [*6]
    |-> duty_stabilise_on == !format_and_stabiliser_select[1]) else $error("stabiliser wrong");
  flag_parallel_a: assert property (!mux_mode_select [*6] |-> !channel_indicator)
    else $error("indicator set in parallel mode");
  word_hold_a: assert property (word_valid && !sink_ready
    |=> word_valid && $stable(first_channel_word) && $stable(channel_indicator)) else $error("word not held");
  pair_order_a: assert property (first_taken |=> word_valid && !channel_indicator)
    else $error("second word missing");
  pair_next_a: assert property (second_taken |=> !word_valid || channel_indicator)
    else $error("first word expected");
endmodule : dao_oc_chk

bind dao_output_control dao_oc_chk #(.WORD_BITS(WORD_BITS)) i_chk (
  .clk_sys, .reset_n, .first_bus_drive_enable_n, .second_bus_drive_enable_n, .sleep_request,
  .mux_mode_select, .format_and_stabiliser_select, .sink_ready, .first_channel_word,
  .first_channel_word_oe, .second_channel_word_oe, .word_valid, .channel_indicator,
  .duty_stabilise_on, .sleeping
);

/* File: tb/dao_sink_model.sv */
// Purpose: receiving logic that collects word pairs from the output buses
// Assumes: mode pin changes only while the buses are idle
// Notes:   a floated bus reads as the inverse of the word behind it
`timescale 1ns/100ps

module dao_sink_model
  import dao_pkg::*;
(
  input  wire logic       clk_sys,                // clock
  input  wire logic       reset_n,                // reset
  input  wire logic       hold,                   // refuse every word
  input  wire logic       slow,                   // take every other cycle
  input  wire logic       mux_mode_select,        // shared bus mode
  input  wire dao_word_t  first_channel_word,     // first bus
  input  wire logic       first_channel_word_oe,  // first driven
  input  wire dao_word_t  second_channel_word,    // second bus
  input  wire logic       second_channel_word_oe, // second driven
  input  wire logic       word_valid,             // word offered
  input  wire logic       channel_indicator,      // channel flag
  output logic            sink_ready,             // taking
  output logic            pair_got,               // pair complete
  output dao_word_t       pair_first,             // first channel word
  output dao_word_t       pair_second             // second channel word
);
  logic      phase;
  dao_word_t bus_a;
  dao_word_t bus_b;

  assign bus_a      = first_channel_word_oe ? first_channel_word : ~first_channel_word;
  assign bus_b      = second_channel_word_oe ? second_channel_word : ~second_channel_word;
  assign sink_ready = !hold && (!slow || phase);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase    <= 1'b0;
      pair_got <= 1'b0;
    end else begin
      phase    <= !phase;
      pair_got <= 1'b0;
      if (word_valid && sink_ready) begin
        if (!mux_mode_select) begin
          pair_first  <= bus_a;
          pair_second <= bus_b;
          pair_got    <= 1'b1;
        end else if (channel_indicator) begin
          pair_first <= bus_a;
        end else begin
          pair_second <= bus_a;
          pair_got    <= 1'b1;
        end
      end
    end
  end
endmodule : dao_sink_model

/* File: tb/dao_output_control_tb.sv */
// Purpose: self-checking bench of the dual converter output control
// Assumes: conversion clock of ten system clocks, pins moved while idle
// Notes:   pairs left in the pipeline are counted, then discarded by sleep
`timescale 1ns/100ps

module dao_output_control_tb;
  import dao_pkg::*;
  logic       clk_sys, reset_n, conv_clk, sleep_request, mux_mode_select;
  logic       first_bus_drive_enable_n, second_bus_drive_enable_n, sink_ready, hold, slow;
  logic [1:0] format_and_stabiliser_select;
  dao_word_t  first_sample, second_sample, first_channel_word, second_channel_word;
  logic       first_channel_word_oe, second_channel_word_oe, word_valid, channel_indicator;
  logic       duty_stabilise_on, sleeping, word_dropped, pair_got, chk_on;
  dao_word_t  pair_first, pair_second, raw, nxt;
  dao_word_t  exp_q[$];
  int         err_count, check_count;

  dao_output_control i_dut (.clk_sys, .reset_n, .conv_clk, .first_sample, .second_sample,
    .first_bus_drive_enable_n, .second_bus_drive_enable_n, .sleep_request, .mux_mode_select,
    .format_and_stabiliser_select, .sink_ready, .first_channel_word, .first_channel_word_oe,
    .second_channel_word, .second_channel_word_oe, .word_valid, .channel_indicator,
    .duty_stabilise_on, .sleeping, .word_dropped);
  dao_sink_model i_sink (.clk_sys, .reset_n, .hold, .slow, .mux_mode_select, .first_channel_word,
    .first_channel_word_oe, .second_channel_word, .second_channel_word_oe, .word_valid,
    .channel_indicator, .sink_ready, .pair_got, .pair_first, .pair_second);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // offset binary with the top bit inverted gives two's complement
  function automatic dao_word_t fmt_word(input dao_word_t w, input logic [1:0] code);
    return (code == 2'h1 || code == 2'h2) ? w ^ 10'h200 : w;
  endfunction : fmt_word

  // one conversion clock period per sample pair
  task automatic conv(input int n);
    for (int i = 0; i < n; i++) begin
      first_sample  = nxt;
      second_sample = nxt ^ 10'h155;
      exp_q.push_back(nxt);
      nxt      = nxt + 10'h04d;
      conv_clk = 1'b1;
      repeat (5) @(negedge clk_sys);
      conv_clk = 1'b0;
      repeat (5) @(negedge clk_sys);
    end
  endtask : conv

  // sleep drops what the pipeline still holds; samples while asleep are lost
  task automatic flush;
    sleep_request = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("sleeping", 10'h001, sleeping);
    check("held pairs", 10'h007, 10'(exp_q.size()));
    conv(3);
    exp_q.delete();
    sleep_request = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("awake", 10'h000, sleeping);
  endtask : flush

  always @(negedge clk_sys) begin
    if (reset_n && pair_got && chk_on) begin
      raw = exp_q.pop_front();
      check("first word", fmt_word(raw, format_and_stabiliser_select), pair_first);
      check("second word", fmt_word(raw ^ 10'h155, format_and_stabiliser_select), pair_second);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #120000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    {reset_n, conv_clk, sleep_request, mux_mode_select, hold, slow} = 6'h00;
    {first_bus_drive_enable_n, second_bus_drive_enable_n} = 2'h0;
    format_and_stabiliser_select = 2'h0;
    first_sample  = 10'h000;
    second_sample = 10'h000;
    nxt    = 10'h3f0;
    chk_on = 1'b1;
    repeat (16) @(negedge clk_sys);
    check("valid in reset", 10'h000, word_valid);
    check("dropped in reset", 10'h000, word_dropped);
    reset_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      {first_bus_drive_enable_n, second_bus_drive_enable_n} = 2'(k);
      repeat (6) @(negedge clk_sys);
      check("first oe", 10'(!first_bus_drive_enable_n), first_channel_word_oe);
      check("second oe", 10'(!second_bus_drive_enable_n), second_channel_word_oe);
    end
    {first_bus_drive_enable_n, second_bus_drive_enable_n} = 2'h0;
    $display("enable test done");
    for (int m = 0; m < 2; m++) begin
      for (int f = 0; f < 4; f++) begin
        mux_mode_select = m[0];
        slow = m[0];
        format_and_stabiliser_select = 2'(f);
        repeat (8) @(negedge clk_sys);
        check("stabiliser", 10'(f < 2), duty_stabilise_on);
        conv(9);
        flush();
        $display("stream test mode %0d format %0d done", m, f);
      end
    end
    check("no loss", 10'h000, word_dropped);
    mux_mode_select = 1'b0;
    chk_on = 1'b0;
    hold = 1'b1;
    conv(12);
    check("overflow", 10'h001, word_dropped);
    check("stalled word", 10'h001, word_valid);
    hold = 1'b0;
    repeat (20) @(negedge clk_sys);
    check("drained", 10'h000, word_valid);
    check("sticky loss", 10'h001, word_dropped);
    reset_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("loss cleared", 10'h000, word_dropped);
    reset_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    $display("buffer test done");
    tally_and_finish();
  end
endmodule : dao_output_control_tb
